// >>> inc/psl_pkg.sv
// Shared constants and types for the status indicator driver.
package psl_pkg;

  // Register byte addresses
  localparam logic [7:0] PSL_ADDR_LED_CTRL = 8'h18;  // Indicator mode control
  localparam logic [7:0] PSL_ADDR_STATUS = 8'h1C;    // Indicator and strap status
  localparam logic [7:0] PSL_ADDR_AUX_CTRL = 8'h20;  // Auxiliary mode control

  // Mode control field positions
  localparam int PSL_TX_MODE_BIT = 0;      // Transmit indicator mode
  localparam int PSL_RX_MODE_BIT = 1;      // Receive indicator mode
  localparam int PSL_DUP_MODE_BIT = 2;     // Duplex indicator mode
  localparam int PSL_LINK_MODE_LSB = 3;    // Link indicator mode field, low bit
  localparam int PSL_LINK_MODE_MSB = 4;    // Link indicator mode field, high bit
  localparam int PSL_LED_CTRL_WIDTH = 5;   // Implemented control bits
  localparam int PSL_FIBER_MODE_BIT = 0;   // Duplex indicator reports fiber link

  // Link mode field value for direct drive
  localparam logic [1:0] PSL_LINK_DIRECT = 2'b00;

  // Reset values
  localparam logic [31:0] PSL_LED_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PSL_AUX_CTRL_RESET = 32'h0000_0000;

  // Status field positions
  localparam int PSL_STAT_LED_LSB = 0;     // Six indicator levels
  localparam int PSL_STAT_STRAP_LSB = 6;   // Six latched strap values
  localparam int PSL_STAT_DONE_BIT = 12;   // Strap capture complete

  // Indicator index order
  localparam int PSL_NUM_LED = 6;
  localparam int PSL_LED_L10 = 0;
  localparam int PSL_LED_L100 = 1;
  localparam int PSL_LED_L1000 = 2;
  localparam int PSL_LED_DUP = 3;
  localparam int PSL_RECEIVE_ACTIVITY_INDICATOR = 4;
  localparam int PSL_TRANSMIT_ACTIVITY_INDICATOR = 5;

  // Speed codes on the speed input
  localparam logic [1:0] PSL_SPEED_10 = 2'b00;
  localparam logic [1:0] PSL_SPEED_100 = 2'b01;
  localparam logic [1:0] PSL_SPEED_1000 = 2'b10;

  // Combined-mode lit pattern {link_10, link_100} per speed
  localparam logic [1:0] PSL_COMBO_10 = 2'b10;
  localparam logic [1:0] PSL_COMBO_100 = 2'b01;
  localparam logic [1:0] PSL_COMBO_1000 = 2'b11;

  // Timing: blink period in milliseconds, clock rate in kHz
  localparam int PSL_BLINK_PERIOD_MS = 100;
  localparam int PSL_CLK_KHZ = 40000;
  localparam int PSL_BLINK_HALF_CYCLES = (PSL_BLINK_PERIOD_MS * PSL_CLK_KHZ) / 2;

  // Strap capture sequencing
  typedef enum logic [0:0] {
    PSL_ST_SAMPLE,
    PSL_ST_RUN
  } psl_state_t;

endpackage

// >>> hdl/psl_stretch.sv
// Activity stretcher that holds a busy flag for at least one blink period.
`timescale 1ns/1ps
module psl_stretch #(
  parameter int HOLD_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic event_in,
  output logic busy
);

  // Counter wide enough for the hold time
  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] HOLD_LOAD = CW'(HOLD_CYCLES);

  logic [CW-1:0] count;       // Remaining hold cycles
  logic [CW-1:0] next_count;  // Next hold count

  // Reload on every event, else count down to zero
  always_comb begin
    next_count = count;
    if (event_in) begin
      next_count = HOLD_LOAD;
    end else if (count != '0) begin
      next_count = count - CW'(1);
    end
  end

  // Register the hold count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Busy while the event lasts or the hold runs
  assign busy = event_in || (count != '0);

endmodule

// >>> hdl/psl_led_driver.sv
// Status indicator driver with strap capture and APB mode registers.
//
// Operation
// - Link indicators active low; field selects mode.
// - Direct mode: 10 indicator shows 10 link.
// - Direct mode: 100 indicator shows 100 link.
// - Direct mode: 1000 indicator shows 1000 link.
// - Combined mode: 1000 indicator shows link only.
// - Control bit picks duplex indicator mode.
// - Duplex mode one: duplex level, collision blink.
// - Duplex mode two: duplex level only.
// - Duplex mode three: fiber link level.
// - Control bit picks receive mode; receiving low.
// - Receive mode two: link level, receive blink.
// - Control bit picks transmit mode; transmitting low.
// - Transmit mode two: link level, activity blink.
// - Indicator pins also serve as straps.
// - Straps latched at reset release, held.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module psl_led_driver
  import psl_pkg::*;
#(
  parameter int BLINK_HALF_CYCLES = PSL_BLINK_HALF_CYCLES,
  parameter logic [1:0] COMBO_10 = PSL_COMBO_10,
  parameter logic [1:0] COMBO_100 = PSL_COMBO_100,
  parameter logic [1:0] COMBO_1000 = PSL_COMBO_1000
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link state from the rest of the device
  input wire logic link_up,
  input wire logic [1:0] link_speed,
  input wire logic full_duplex,
  input wire logic collision,
  input wire logic rx_active,
  input wire logic tx_active,
  input wire logic fiber_link_up,
  // Indicator pins: input, output, output enable (low = driving)
  input wire logic [5:0] indicator_in,
  output logic link_10_indicator,
  output logic link_100_indicator,
  output logic link_1000_indicator,
  output logic duplex_indicator,
  output logic receive_activity_indicator,
  output logic transmit_activity_indicator,
  output logic [5:0] indicator_oe_n,
  // Latched strap configuration
  output logic [5:0] config_strap,
  output logic config_valid
);

  // Address match, used by read and write decode
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] reg_addr);
    addr_is = (a[7:2] == reg_addr[7:2]);
  endfunction

  // Mapped address check
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = addr_is(a, PSL_ADDR_LED_CTRL) || addr_is(a, PSL_ADDR_STATUS) ||
                  addr_is(a, PSL_ADDR_AUX_CTRL);
  endfunction

  // ---------------- APB register file ----------------
  logic [PSL_LED_CTRL_WIDTH-1:0] led_ctrl;       // Mode control
  logic [PSL_LED_CTRL_WIDTH-1:0] next_led_ctrl;
  logic fiber_mode;                              // Duplex indicator shows fiber
  logic next_fiber_mode;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] status_word;                      // Live status view
  logic access;                                  // Access phase awaiting answer
  logic commit;                                  // Transfer completes this edge

  // Exactly one wait state: the answer flops one cycle into the access
  assign access = psel && penable && !pready;
  assign commit = psel && penable && pready;

  // Status view: indicator levels, straps, capture done
  always_comb begin
    status_word = '0;
    status_word[PSL_STAT_LED_LSB +: PSL_NUM_LED] = {transmit_activity_indicator,
      receive_activity_indicator, duplex_indicator, link_1000_indicator,
      link_100_indicator, link_10_indicator};
    status_word[PSL_STAT_STRAP_LSB +: PSL_NUM_LED] = config_strap;
    status_word[PSL_STAT_DONE_BIT] = config_valid;
  end

  // Bus answer and register writes; one wait state per transfer
  always_comb begin
    next_led_ctrl = led_ctrl;
    next_fiber_mode = fiber_mode;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (access) begin
      // Answer on the next edge
      next_pready = 1'b1;
      next_pslverr = !addr_mapped(paddr);
      next_prdata = '0;
      if (!pwrite) begin
        if (addr_is(paddr, PSL_ADDR_LED_CTRL)) begin
          next_prdata[PSL_LED_CTRL_WIDTH-1:0] = led_ctrl;
        end else if (addr_is(paddr, PSL_ADDR_STATUS)) begin
          next_prdata = status_word;
        end else if (addr_is(paddr, PSL_ADDR_AUX_CTRL)) begin
          next_prdata[PSL_FIBER_MODE_BIT] = fiber_mode;
        end
      end
    end else if (commit && pwrite) begin
      // Write lands at the completing edge
      if (addr_is(paddr, PSL_ADDR_LED_CTRL)) begin
        next_led_ctrl = pwdata[PSL_LED_CTRL_WIDTH-1:0];
      end else if (addr_is(paddr, PSL_ADDR_AUX_CTRL)) begin
        next_fiber_mode = pwdata[PSL_FIBER_MODE_BIT];
      end
    end
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_ctrl <= PSL_LED_CTRL_RESET[PSL_LED_CTRL_WIDTH-1:0];
      fiber_mode <= PSL_AUX_CTRL_RESET[PSL_FIBER_MODE_BIT];
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      led_ctrl <= next_led_ctrl;
      fiber_mode <= next_fiber_mode;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ---------------- Blink timebase ----------------
  // Free-running so every blinking indicator stays in step
  localparam int BW = $clog2(BLINK_HALF_CYCLES + 1);
  localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_HALF_CYCLES - 1);

  logic [BW-1:0] blink_count;       // Half-period counter
  logic [BW-1:0] next_blink_count;
  logic blink_phase;                // High during the half in which a blinking indicator is inverted
  logic next_blink_phase;

  // Free-running square wave at the blink rate
  always_comb begin
    next_blink_count = blink_count + BW'(1);
    next_blink_phase = blink_phase;
    if (blink_count == BLINK_LAST) begin
      next_blink_count = '0;
      next_blink_phase = !blink_phase;
    end
  end

  // Blink timebase flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_count <= '0;
      blink_phase <= 1'b0;
    end else begin
      blink_count <= next_blink_count;
      blink_phase <= next_blink_phase;
    end
  end

  // Stretch collision, receive and any activity to a full blink
  logic [2:0] act_event;   // Raw events
  logic [2:0] act_busy;    // Stretched events
  assign act_event = {rx_active || tx_active, rx_active, collision};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_stretch
      psl_stretch #(
        .HOLD_CYCLES(2 * BLINK_HALF_CYCLES)
      ) u_stretch (
        .pclk(pclk),
        .presetn(presetn),
        .event_in(act_event[gi]),
        .busy(act_busy[gi])
      );
    end
  endgenerate

  // ---------------- Indicator levels ----------------
  logic [5:0] lit;         // Active-high lit request per indicator
  logic [1:0] combo;       // Combined-mode pattern for the speed

  // Lit requests from modes and link state
  always_comb begin
    lit = '0;
    combo = 2'b00;
    case (link_speed)
      PSL_SPEED_10: combo = COMBO_10;
      PSL_SPEED_100: combo = COMBO_100;
      PSL_SPEED_1000: combo = COMBO_1000;
      default: combo = 2'b00;
    endcase
    if (led_ctrl[PSL_LINK_MODE_MSB:PSL_LINK_MODE_LSB] == PSL_LINK_DIRECT) begin
      lit[PSL_LED_L10] = link_up && (link_speed == PSL_SPEED_10);
      lit[PSL_LED_L100] = link_up && (link_speed == PSL_SPEED_100);
      lit[PSL_LED_L1000] = link_up && (link_speed == PSL_SPEED_1000);
    end else begin
      // Speed readable from the 10 and 100 indicators together
      lit[PSL_LED_L10] = link_up && combo[1];
      lit[PSL_LED_L100] = link_up && combo[0];
      lit[PSL_LED_L1000] = link_up;
    end
    // Duplex indicator
    if (fiber_mode) begin
      lit[PSL_LED_DUP] = fiber_link_up;
    end else if (!led_ctrl[PSL_DUP_MODE_BIT]) begin
      lit[PSL_LED_DUP] = full_duplex ^ (act_busy[0] && blink_phase);
    end else begin
      lit[PSL_LED_DUP] = full_duplex;
    end
    // Receive indicator
    if (!led_ctrl[PSL_RX_MODE_BIT]) begin
      lit[PSL_RECEIVE_ACTIVITY_INDICATOR] = rx_active;
    end else begin
      lit[PSL_RECEIVE_ACTIVITY_INDICATOR] = link_up && !(act_busy[1] && blink_phase);
    end
    // Transmit indicator
    if (!led_ctrl[PSL_TX_MODE_BIT]) begin
      lit[PSL_TRANSMIT_ACTIVITY_INDICATOR] = tx_active;
    end else begin
      lit[PSL_TRANSMIT_ACTIVITY_INDICATOR] = link_up && !(act_busy[2] && blink_phase);
    end
  end

  // ---------------- Strap capture and pin drive ----------------
  // Pins stay released one edge past reset so board straps read cleanly
  psl_state_t state;            // Capture sequencing
  psl_state_t next_state;
  logic [5:0] next_config_strap;
  logic next_config_valid;
  logic [5:0] led_level;        // Registered pin levels
  logic [5:0] next_led_level;
  logic [5:0] next_oe_n;

  // Sample pins once after release, then drive them
  always_comb begin
    next_state = state;
    next_config_strap = config_strap;
    next_config_valid = config_valid;
    next_led_level = {PSL_NUM_LED{1'b1}};
    next_oe_n = {PSL_NUM_LED{1'b1}};
    case (state)
      PSL_ST_SAMPLE: begin
        next_config_strap = indicator_in;
        next_config_valid = 1'b1;
        next_state = PSL_ST_RUN;
      end
      PSL_ST_RUN: begin
        next_led_level = ~lit;
        next_oe_n = '0;
      end
      default: next_state = PSL_ST_SAMPLE;
    endcase
  end

  // Strap and pin flops; straps change only through reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PSL_ST_SAMPLE;
      config_strap <= '0;
      config_valid <= 1'b0;
      led_level <= {PSL_NUM_LED{1'b1}};
      indicator_oe_n <= {PSL_NUM_LED{1'b1}};
    end else begin
      state <= next_state;
      config_strap <= next_config_strap;
      config_valid <= next_config_valid;
      led_level <= next_led_level;
      indicator_oe_n <= next_oe_n;
    end
  end

  // Pin outputs straight from the level flops
  // No logic after the flops, so the pins never glitch
  assign link_10_indicator = led_level[PSL_LED_L10];
  assign link_100_indicator = led_level[PSL_LED_L100];
  assign link_1000_indicator = led_level[PSL_LED_L1000];
  assign duplex_indicator = led_level[PSL_LED_DUP];
  assign receive_activity_indicator = led_level[PSL_RECEIVE_ACTIVITY_INDICATOR];
  assign transmit_activity_indicator = led_level[PSL_TRANSMIT_ACTIVITY_INDICATOR];

endmodule

// >>> bench/psl_led_board.sv
// Board model: indicator LEDs with a strap resistor on every pin.
`timescale 1ns/1ps
module psl_led_board (
  input wire logic [5:0] strap,
  input wire logic [5:0] drive,
  input wire logic [5:0] oe_n,
  output logic [5:0] pin,
  output logic [2:0] link_lit
);
  // Released pin settles to its strap level
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin[i] = oe_n[i] ? strap[i] : drive[i];
    end
  end
  // All three link pins sampled at once, low means lit
  assign link_lit = ~pin[2:0];
endmodule

// >>> bench/psl_led_monitor.sv
// Checker watching the status indicator driver ports.
`timescale 1ns/1ps
module psl_led_monitor
  import psl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic link_up,
  input wire logic [1:0] link_speed,
  input wire logic full_duplex,
  input wire logic rx_active,
  input wire logic tx_active,
  input wire logic fiber_link_up,
  input wire logic [5:0] indicator_in,
  input wire logic link_10_indicator,
  input wire logic link_100_indicator,
  input wire logic link_1000_indicator,
  input wire logic duplex_indicator,
  input wire logic receive_activity_indicator,
  input wire logic transmit_activity_indicator,
  input wire logic [5:0] indicator_oe_n,
  input wire logic [5:0] config_strap,
  input wire logic config_valid
);
  logic [4:0] mode; // Mirror of mode control
  logic fib; // Mirror of fiber select
  logic run; // Pins were driven
  logic [4:0] next_mode;
  logic next_fib;
  logic next_run;
  logic wr; // Write landing now
  // Mirror register writes as they land
  always_comb begin
    wr = psel && penable && pwrite && pready;
    next_mode = (wr && paddr[7:2] == PSL_ADDR_LED_CTRL[7:2]) ? pwdata[4:0] : mode;
    next_fib = (wr && paddr[7:2] == PSL_ADDR_AUX_CTRL[7:2]) ? pwdata[0] : fib;
    next_run = indicator_oe_n == 6'h00;
  end
  // Mirror registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= 5'h00;
      fib <= 1'b0;
      run <= 1'b0;
    end else begin
      mode <= next_mode;
      fib <= next_fib;
      run <= next_run;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  strap_capture_a: assert property ($rose(config_valid) |->
    config_strap == $past(indicator_in)) else $error("strap capture wrong");
  strap_hold_a: assert property (config_valid && $past(config_valid) |->
    $stable(config_strap)) else $error("strap changed");
  pins_released_a: assert property (!config_valid |-> indicator_oe_n == 6'h3F)
    else $error("pins driven too early");
  link_direct_a: assert property (run && $past(mode[4:3]) == 2'h0 |->
    {link_1000_indicator, link_100_indicator, link_10_indicator} == ~({3{$past(link_up)}}
    & {$past(link_speed) == 2'h2, $past(link_speed) == 2'h1, $past(link_speed) == 2'h0}))
    else $error("direct link wrong");
  link_combined_a: assert property (run && $past(mode[4:3]) != 2'h0 |->
    link_1000_indicator == !$past(link_up)) else $error("combined link wrong");
  duplex_fiber_a: assert property (run && $past(fib) |->
    duplex_indicator == !$past(fiber_link_up)) else $error("fiber indicator wrong");
  duplex_level_a: assert property (run && $past(mode[2]) && !$past(fib) |->
    duplex_indicator == !$past(full_duplex)) else $error("duplex indicator wrong");
  rx_level_a: assert property (run && !$past(mode[1]) |->
    receive_activity_indicator == !$past(rx_active)) else $error("receive wrong");
  tx_level_a: assert property (run && !$past(mode[0]) |->
    transmit_activity_indicator == !$past(tx_active)) else $error("transmit wrong");
  rx_dark_a: assert property (run && $past(mode[1]) && !$past(link_up) |->
    receive_activity_indicator) else $error("receive lit without link");
  bus_answer_a: assert property (psel && penable && !pready |=> pready && pslverr ==
    !(paddr[7:2] inside {6'h06, 6'h07, 6'h08})) else $error("bus answer wrong");
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the status indicator driver.
`timescale 1ns/1ps
module tb_top;
  import psl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, cfg_valid;
  logic link_up, full_duplex, collision, rx_active, tx_active, fiber_link_up;
  logic [1:0] link_speed, combo; // Speed code, expected combined pattern
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] oe_n, strap, cfg_strap; // Enables, board straps, latched straps
  logic [2:0] link_lit; // Lit link pins
  wire [5:0] led, pin; // Driven levels, pin levels
  int mismatches, n_checks, cnt;
  psl_led_driver #(.BLINK_HALF_CYCLES(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_up(link_up), .link_speed(link_speed), .full_duplex(full_duplex),
    .collision(collision), .rx_active(rx_active), .tx_active(tx_active),
    .fiber_link_up(fiber_link_up), .indicator_in(pin), .link_10_indicator(led[0]),
    .link_100_indicator(led[1]), .link_1000_indicator(led[2]), .duplex_indicator(led[3]),
    .receive_activity_indicator(led[4]), .transmit_activity_indicator(led[5]),
    .indicator_oe_n(oe_n), .config_strap(cfg_strap), .config_valid(cfg_valid));
  psl_led_board board (.strap(strap), .drive(led), .oe_n(oe_n), .pin(pin), .link_lit(link_lit));
  // Clock, 25 ns period
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Hang guard
  initial begin
    #(25 * 20000);
    mismatches++;
    tally_and_finish;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One bus transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk(32'(err), 32'(e));
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, x);
    chk(32'(err), 32'(e));
  endtask
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // Count cycles with one indicator dark
  task automatic count_dark(input int b, input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge pclk);
      #1;
      cnt += int'(led[b] === 1'b1);
    end
  endtask
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Test sequence
  initial begin
    {psel, penable, pwrite, link_up, full_duplex, collision, rx_active, tx_active} = '0;
    {fiber_link_up, paddr, pwdata, link_speed} = '0;
    strap = 6'h29;
    presetn = 1'b0;
    do_reset;
    chk(32'(cfg_strap), 32'h0000_0029);
    chk(32'(oe_n), 32'h0000_0000);
    rdc(PSL_ADDR_STATUS, {19'h0_0000, 1'b1, 6'h29, 6'h3F}, 1'b0);
    rdc(PSL_ADDR_LED_CTRL, PSL_LED_CTRL_RESET, 1'b0);
    rdc(PSL_ADDR_AUX_CTRL, PSL_AUX_CTRL_RESET, 1'b0);
    $display("reset test done");
    for (int s = 0; s < 4; s++) begin
      @(posedge pclk);
      link_up <= 1'b1;
      link_speed <= 2'(s);
      settle;
      chk(32'(link_lit), 32'({s == 2, s == 1, s == 0}));
    end
    for (int m = 1; m < 4; m++) begin
      wrc(PSL_ADDR_LED_CTRL, 32'(m) << 3, 1'b0);
      for (int s = 0; s < 3; s++) begin
        @(posedge pclk);
        link_up <= 1'b1;
        link_speed <= 2'(s);
        combo = (s == 0) ? PSL_COMBO_10 : (s == 1) ? PSL_COMBO_100 : PSL_COMBO_1000;
        settle;
        chk(32'(link_lit), 32'({1'b1, combo[0], combo[1]}));
      end
    end
    $display("link test done");
    wrc(PSL_ADDR_LED_CTRL, 32'h0000_0004, 1'b0);
    for (int f = 0; f < 2; f++) begin
      @(posedge pclk);
      full_duplex <= 1'(f);
      collision <= 1'b1;
      fiber_link_up <= 1'(f == 0);
      settle;
      chk(32'(led[3]), 32'(f == 0));
      wrc(PSL_ADDR_AUX_CTRL, 32'h0000_0001, 1'b0);
      settle;
      chk(32'(led[3]), 32'(f == 1));
      wrc(PSL_ADDR_AUX_CTRL, 32'h0000_0000, 1'b0);
    end
    wrc(PSL_ADDR_LED_CTRL, 32'h0000_0000, 1'b0);
    @(posedge pclk);
    collision <= 1'b0;
    repeat (12) @(posedge pclk);
    count_dark(3, 12);
    chk(32'(cnt), 32'h0000_0000);
    @(posedge pclk);
    collision <= 1'b1;
    @(posedge pclk);
    collision <= 1'b0;
    count_dark(3, 12);
    chk(32'(cnt > 0), 32'h0000_0001);
    $display("duplex test done");
    for (int a = 0; a < 2; a++) begin
      @(posedge pclk);
      rx_active <= 1'(a);
      tx_active <= 1'(a == 0);
      settle;
      chk(32'(led[5:4]), 32'({a == 1, a == 0}));
    end
    wrc(PSL_ADDR_LED_CTRL, 32'h0000_0003, 1'b0);
    @(posedge pclk);
    {rx_active, tx_active} <= 2'h0;
    repeat (12) @(posedge pclk);
    count_dark(5, 12);
    chk(32'(cnt), 32'h0000_0000);
    @(posedge pclk);
    rx_active <= 1'b1;
    // Steady activity: half of any 16 cycles dark with a half period of 4
    count_dark(5, 16);
    chk(32'(cnt), 32'h0000_0008);
    count_dark(4, 16);
    chk(32'(cnt), 32'h0000_0008);
    @(posedge pclk);
    {rx_active, link_up} <= 2'h0;
    settle;
    chk(32'(led[5:4]), 32'h0000_0003);
    $display("activity test done");
    wrc(PSL_ADDR_LED_CTRL, 32'hFFFF_FFFF, 1'b0);
    rdc(PSL_ADDR_LED_CTRL, 32'h0000_001F, 1'b0);
    wrc(PSL_ADDR_STATUS, 32'h0000_0000, 1'b0);
    wrc(8'h24, 32'h0000_0001, 1'b1);
    rdc(8'h24, 32'h0000_0000, 1'b1);
    wrc(PSL_ADDR_LED_CTRL, 32'h0000_0000, 1'b0);
    @(posedge pclk);
    strap <= 6'h16;
    settle;
    rdc(PSL_ADDR_STATUS, {19'h0_0000, 1'b1, 6'h29, 6'h37}, 1'b0);
    do_reset;
    chk(32'(cfg_strap), 32'h0000_0016);
    $display("bus and strap test done");
    tally_and_finish;
  end
endmodule
bind psl_led_driver psl_led_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .link_up, .link_speed, .full_duplex, .rx_active, .tx_active,
  .fiber_link_up, .indicator_in, .link_10_indicator, .link_100_indicator, .link_1000_indicator,
  .duplex_indicator, .receive_activity_indicator, .transmit_activity_indicator,
  .indicator_oe_n, .config_strap, .config_valid);
